// *** cmd_port_pkg.sv ***
// Package for the paged register command port: command word layout,
// page numbers, register offsets, fill value, state codes and decoders.
// Assumes a 16-bit command word followed by 16-bit data words.
package cmd_port_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Word and command layout
  localparam int WORD_W = 16;
  localparam int DIR_BIT = 15;
  localparam int PAGE_MSB = 14;
  localparam int PAGE_LSB = 11;
  localparam int ADDR_MSB = 10;
  localparam int ADDR_LSB = 5;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 7;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [PTR_W-1:0] PTR_STEP = 7'h01;
  localparam logic [15:0] FILL_WORD = 16'hffff;
  localparam logic [15:0] IDLE_TX = 16'h0000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] CMD_READ_P0 = 16'h8000;
  localparam logic [15:0] CMD_WRITE_P1 = 16'h0800;

  ////////////////////////////////////////////////////////////////////////
  // Page numbers
  localparam logic [3:0] PAGE_RESULTS = 4'h0;
  localparam logic [3:0] PAGE_CTRL_A = 4'h1;
  localparam logic [3:0] PAGE_CTRL_B = 4'h2;
  localparam logic [3:0] PAGE_BUFFER = 4'h3;

  // Page 0 offsets
  localparam logic [5:0] TOUCH_X_RESULT = 6'h00;
  localparam logic [5:0] TOUCH_Y_RESULT = 6'h01;
  localparam logic [5:0] TOUCH_PRESSURE_A = 6'h02;
  localparam logic [5:0] TOUCH_PRESSURE_B = 6'h03;
  localparam logic [5:0] CELL_VOLTAGE_RESULT = 6'h05;
  localparam logic [5:0] AUXILIARY_IN1_RESULT = 6'h07;
  localparam logic [5:0] AUXILIARY_IN2_RESULT = 6'h08;
  localparam logic [5:0] THERMAL_READING_A = 6'h09;
  localparam logic [5:0] THERMAL_READING_B = 6'h0a;
  // Page 1 offsets
  localparam logic [5:0] TOUCH_CONVERTER_CONTROL = 6'h00;
  localparam logic [5:0] CONVERTER_STATUS = 6'h01;
  localparam logic [5:0] FIFO_MODE_CONTROL = 6'h02;
  localparam logic [5:0] REFERENCE_CONTROL = 6'h03;
  localparam logic [5:0] SOFT_RESET_CONTROL = 6'h04;
  localparam logic [5:0] CONVERTER_CONFIGURATION = 6'h05;
  localparam logic [5:0] THERMAL_UPPER_LIMIT = 6'h06;
  localparam logic [5:0] THERMAL_LOWER_LIMIT = 6'h07;
  localparam logic [5:0] AUXILIARY_IN1_UPPER_LIMIT = 6'h08;
  localparam logic [5:0] AUXILIARY_IN1_LOWER_LIMIT = 6'h09;
  localparam logic [5:0] AUXILIARY_IN2_UPPER_LIMIT = 6'h0a;
  localparam logic [5:0] AUXILIARY_IN2_LOWER_LIMIT = 6'h0b;
  localparam logic [5:0] MEASUREMENT_SETUP = 6'h0c;
  localparam logic [5:0] INTERVAL_DELAY_CONTROL = 6'h0d;

  ////////////////////////////////////////////////////////////////////////
  // Transaction states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } xfer_state_t;

  // Pages 0..3 exist; all other codes select nothing
  function automatic logic page_valid(input logic [3:0] page);
    page_valid = (page[3:2] == 2'b00);
  endfunction

  // Only the two control pages accept writes from the serial port
  function automatic logic page_writable(input logic [3:0] page);
    page_writable = (page == PAGE_CTRL_A) || (page == PAGE_CTRL_B);
  endfunction

endpackage

// *** paged_word_memory.sv ***
// Word memory behind the command port: four pages of 64 words of 16 bits.
// Assumes one clock; port a wins over port b on the same address.
`timescale 1ns/1ps
module paged_word_memory
  import cmd_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_a_i,
  input wire logic [MEM_AW-1:0] addr_a_i,
  input wire logic [WORD_W-1:0] data_a_i,
  input wire logic wr_b_i,
  input wire logic [MEM_AW-1:0] addr_b_i,
  input wire logic [WORD_W-1:0] data_b_i,
  input wire logic [MEM_AW-1:0] rd_addr_i,
  output logic [WORD_W-1:0] rd_data_o
);

  logic [WORD_W-1:0] mem [MEM_DEPTH];

  // Writes; port a last so the serial port wins a collision
  always_ff @(posedge clk_i)
  begin
    if (wr_b_i)
    begin
      mem[addr_b_i] <= data_b_i;
    end
    if (wr_a_i)
    begin
      mem[addr_a_i] <= data_a_i;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge clk_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// *** paged_register_command_port.sv ***
// Serial command port for a four-page map of 16-bit registers.
// Assumes a master with idle-low clock, data launched on the first edge;
// sclk_i runs only inside frames and is far slower than clk_i.
`timescale 1ns/1ps

// Contract
// R01: Each access is a 16-bit command word, then data words.
// R02: Command bit 15 set means read, clear means write.
// R03: Next four bits select the page, most significant first.
// R04: Next six bits give the starting register address.
// R05: Master sends the last five command bits as zero.
// R06: Pages 0 to 3 exist; other page codes select nothing.
// R07: Command 0x8000 reads from page 0, address 0.
// R08: Pointer advances one per read word up to page end.
// R09: Reads past the page end return 0xFFFF.
// R10: Command 0x0800 writes from page 1, address 0.
// R11: Every register and every data transfer is 16 bits.
// R12: Page 0 results, pages 1-2 control, page 3 buffer data.
// R13: Commands count only after slave select falls.
// R14: Clock idles low; both sides launch on the first edge.
// R15: Write words stored at the pointer, then pointer advances.
// R16: Slave select high ends the transaction, drops partial words.
module paged_register_command_port
  import cmd_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic load_wr_i,
  input wire logic [1:0] load_page_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [WORD_W-1:0] load_data_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic frame_busy_o,
  output logic ctrl_wr_o,
  output logic [1:0] ctrl_wr_page_o,
  output logic [ADDR_W-1:0] ctrl_wr_addr_o,
  output logic [WORD_W-1:0] ctrl_wr_data_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rst_meta;
  logic rst_n;
  logic [3:0] bit_cnt;
  logic [WORD_W-2:0] rx_sh;
  logic first_word;
  logic [WORD_W-1:0] word_buf;
  logic word_first;
  logic word_tgl;
  logic [WORD_W-1:0] tx_sh;
  logic [WORD_W-1:0] load_word;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic ss_s1;
  logic ss_s2;
  logic word_evt;
  logic is_cmd;
  logic data_evt;
  xfer_state_t state;
  logic [3:0] page_r;
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic [3:0] rd_page;
  logic fetch_pend;
  logic fetch_ok;
  logic [WORD_W-1:0] tx_word;
  logic [WORD_W-1:0] mem_q;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  logic [MEM_AW-1:0] load_addr;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: receive side, sampled on the falling (second) edge.
  // Slave select high clears it, so a partial word is simply dropped.
  always_ff @(negedge sclk_i or posedge ss_n_i)
  begin
    if (ss_n_i)
    begin
      bit_cnt <= BIT_FIRST; // R16
      rx_sh <= '0;
      first_word <= 1'b1; // R13
    end
    else
    begin
      bit_cnt <= bit_cnt + BIT_STEP; // R11
      rx_sh <= {rx_sh[WORD_W-3:0], mosi_i};
      if (bit_cnt == BIT_LAST)
      begin
        first_word <= 1'b0;
      end
    end
  end

  // Completed word, held for a whole word time; toggle flags it across
  always_ff @(negedge sclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_buf <= RESET_WORD;
      word_first <= 1'b0;
      word_tgl <= 1'b0;
    end
    else if (bit_cnt == BIT_LAST)
    begin
      word_buf <= {rx_sh, mosi_i}; // R01
      word_first <= first_word; // R13
      word_tgl <= ~word_tgl;
    end
  end

  // Nothing meaningful to return while the command itself shifts in
  assign load_word = first_word ? IDLE_TX : tx_word;

  // Transmit side, launched on the rising (first) edge of each bit.
  // tx_word is settled well before the first bit of the next word.
  always_ff @(posedge sclk_i or posedge ss_n_i)
  begin
    if (ss_n_i)
    begin
      tx_sh <= IDLE_TX;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      miso_oe_o <= 1'b1;
      if (bit_cnt == BIT_FIRST)
      begin
        miso_o <= load_word[WORD_W-1]; // R14
        tx_sh <= {load_word[WORD_W-2:0], 1'b0};
      end
      else
      begin
        miso_o <= tx_sh[WORD_W-1]; // R14
        tx_sh <= {tx_sh[WORD_W-2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock: toggle and slave select, two stages
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
    end
    else
    begin
      tgl_s1 <= word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      ss_s1 <= ss_n_i;
      ss_s2 <= ss_s1;
    end
  end

  // One-cycle word event; the first word of a frame is the command
  assign word_evt = tgl_s2 ^ tgl_s3;
  assign is_cmd = word_evt && word_first; // R13
  assign data_evt = word_evt && !word_first;

  ////////////////////////////////////////////////////////////////////////
  // Command decode and transaction state.
  // Reserved low command bits are never looked at.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
    end
    else if (is_cmd)
    begin
      state <= word_buf[DIR_BIT] ? ST_READ : ST_WRITE; // R02 R07 R10
    end
    else if (ss_s2 && !word_evt)
    begin
      state <= ST_IDLE; // R16
    end
  end

  // Page kept as all four bits so a reserved code stays reserved
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_r <= PAGE_RESULTS;
    end
    else if (is_cmd)
    begin
      page_r <= word_buf[PAGE_MSB:PAGE_LSB]; // R03
    end
  end

  // Pointer: loaded by the command, then one step per data word up to the page end
  always_comb
  begin
    next_ptr = ptr;
    if (is_cmd)
    begin
      next_ptr = {1'b0, word_buf[ADDR_MSB:ADDR_LSB]}; // R04
    end
    else if (data_evt && (state != ST_IDLE) && !ptr[PTR_W-1])
    begin
      next_ptr = ptr + PTR_STEP; // R08 R15
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr <= '0;
    end
    else
    begin
      ptr <= next_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: fetch at the new pointer in the event cycle itself,
  // so the word is ready before the master starts the next one
  assign rd_page = is_cmd ? word_buf[PAGE_MSB:PAGE_LSB] : page_r;
  assign rd_addr = {rd_page[1:0], next_ptr[ADDR_W-1:0]};

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_pend <= 1'b0;
      fetch_ok <= 1'b0;
    end
    else
    begin
      fetch_pend <= word_evt;
      fetch_ok <= page_valid(rd_page) && !next_ptr[PTR_W-1]; // R06 R09
    end
  end

  // Past the page end, or on a reserved page, the filler goes out
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_word <= FILL_WORD;
    end
    else if (fetch_pend)
    begin
      tx_word <= fetch_ok ? mem_q : FILL_WORD; // R09
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path: result and buffer pages are read-only from the link
  assign wr_en = data_evt && (state == ST_WRITE) && page_writable(page_r)
    && !ptr[PTR_W-1]; // R12 R15
  assign wr_addr = {page_r[1:0], ptr[ADDR_W-1:0]};
  assign load_addr = {load_page_i, load_addr_i};

  // Notice of each stored control word for the logic it steers
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_wr_o <= 1'b0;
      ctrl_wr_page_o <= '0;
      ctrl_wr_addr_o <= '0;
      ctrl_wr_data_o <= RESET_WORD;
    end
    else
    begin
      ctrl_wr_o <= wr_en; // R15
      if (wr_en)
      begin
        ctrl_wr_page_o <= page_r[1:0];
        ctrl_wr_addr_o <= ptr[ADDR_W-1:0];
        ctrl_wr_data_o <= word_buf; // R11
      end
    end
  end

  // Frame status for the rest of the chip
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_busy_o <= 1'b0;
    end
    else
    begin
      frame_busy_o <= !ss_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage; the load port fills results and buffer pages
  paged_word_memory u_mem (
    .clk_i(clk_i),
    .wr_a_i(wr_en),
    .addr_a_i(wr_addr),
    .data_a_i(word_buf),
    .wr_b_i(load_wr_i),
    .addr_b_i(load_addr),
    .data_b_i(load_data_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks on the system clock side
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  AST_DIR_DECODE: assert property ( // R02
    is_cmd |=> (state == (word_buf[DIR_BIT] ? ST_READ : ST_WRITE)))
    else $error("direction bit not decoded");

  AST_PAGE_DECODE: assert property ( // R03
    is_cmd |=> (page_r == $past(word_buf[PAGE_MSB:PAGE_LSB])))
    else $error("page field not decoded");

  AST_ADDR_DECODE: assert property ( // R04
    is_cmd |=> (ptr == {1'b0, $past(word_buf[ADDR_MSB:ADDR_LSB])}))
    else $error("start address not decoded");

  AST_RESERVED_PAGE: assert property ( // R06
    (word_evt && !page_valid(rd_page)) |=> ##1 (tx_word == FILL_WORD))
    else $error("reserved page returned data");

  AST_CMD_READ_P0: assert property ( // R07
    (is_cmd && word_buf == CMD_READ_P0)
      |=> (state == ST_READ) && (page_r == PAGE_RESULTS) && (ptr == '0))
    else $error("read of page 0 not started");

  AST_READ_STEP: assert property ( // R08
    (data_evt && state == ST_READ && !ptr[PTR_W-1]) |=> (ptr == $past(ptr) + PTR_STEP))
    else $error("read pointer did not advance");

  AST_FILL_PAST_END: assert property ( // R09
    (data_evt && state == ST_READ && ptr == 7'h3f) |=> ##1 (tx_word == FILL_WORD))
    else $error("filler missing past page end");

  AST_CMD_WRITE_P1: assert property ( // R10
    (is_cmd && word_buf == CMD_WRITE_P1)
      |=> (state == ST_WRITE) && (page_r == PAGE_CTRL_A) && (ptr == '0))
    else $error("write of page 1 not started");

  AST_RO_PAGES: assert property ( // R12
    (data_evt && state == ST_WRITE && !page_writable(page_r)) |=> !ctrl_wr_o)
    else $error("write accepted on a read-only page");

  AST_WRITE_STORE: assert property ( // R15
    (data_evt && state == ST_WRITE && page_writable(page_r) && !ptr[PTR_W-1])
      |=> ctrl_wr_o && (ctrl_wr_data_o == $past(word_buf))
        && (ctrl_wr_addr_o == $past(ptr[ADDR_W-1:0])))
    else $error("write word not stored at pointer");

  AST_FRAME_END: assert property ( // R16
    (ss_s2 && !word_evt) |=> (state == ST_IDLE))
    else $error("frame end did not close transaction");

  AST_TX_READY: assert property ( // R14
    word_evt |-> ##[1:3] $stable(tx_word) [*3])
    else $error("reply word not settled in time");

  // Main scenarios
  COV_READ_CMD: cover property (is_cmd && word_buf[DIR_BIT]);
  COV_WRITE_WORD: cover property (ctrl_wr_o);
  COV_PAST_END: cover property (fetch_pend && !fetch_ok && page_valid(page_r));
  COV_FRAME_END: cover property ((state != ST_IDLE) ##1 (state == ST_IDLE));

endmodule

// *** spi_host_model.sv ***
// Behavioural serial master that drives the command port's link pins.
// Assumes an 80 ns link clock, idle low, data launched on the rising edge.
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  ////////////////////////////////////////////////////////////////////////
  // Idle levels: clock low, select high
  initial
  begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Select falls first, so the next word counts as a command
  task automatic open_frame();
    // Odd offset keeps link edges off the system clock edges
    #1.3;
    ss_n_o = 1'b0;
    #40;
  endtask

  // Shift n bits MSB first; launch on rising, sample on falling
  task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - n; i--)
    begin
      sclk_o = 1'b1;
      mosi_o = tx[i];
      #40;
      sclk_o = 1'b0;
      rx[i] = miso_i;
      #40;
    end
  endtask

  // Clock stays still between frames; data line flipped so no stale bit
  task automatic close_frame();
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the paged register command port.
// Assumes the serial master model above and a 250 MHz system clock.
`timescale 1ns/1ps
module tb_top;
  import cmd_port_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sclk_i, ss_n_i, mosi_i, miso_o, miso_oe_o, frame_busy_o, ctrl_wr_o;
  logic load_wr_i = 1'b0;
  logic [1:0] load_page_i = 2'h0;
  logic [ADDR_W-1:0] load_addr_i = 6'h00;
  logic [WORD_W-1:0] load_data_i = 16'h0000;
  logic [1:0] ctrl_wr_page_o;
  logic [ADDR_W-1:0] ctrl_wr_addr_o;
  logic [WORD_W-1:0] ctrl_wr_data_o;
  logic [31:0] seed = 32'h0000003c;
  logic [15:0] mem [256];
  logic [23:0] exp_q [$];
  logic [23:0] obs_q [$];
  int error_cnt = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  paged_register_command_port i_paged_register_command_port (
    .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .ss_n_i(ss_n_i),
    .mosi_i(mosi_i), .load_wr_i(load_wr_i), .load_page_i(load_page_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .frame_busy_o(frame_busy_o), .ctrl_wr_o(ctrl_wr_o),
    .ctrl_wr_page_o(ctrl_wr_page_o), .ctrl_wr_addr_o(ctrl_wr_addr_o),
    .ctrl_wr_data_o(ctrl_wr_data_o));

  spi_host_model i_spi_host_model (
    .sclk_o(sclk_i), .ss_n_o(ss_n_i), .mosi_o(mosi_i), .miso_i(miso_o));

  // Record every stored serial write for later comparison
  always @(posedge clk_i)
  begin
    if (ctrl_wr_o === 1'b1)
      obs_q.push_back({ctrl_wr_page_o, ctrl_wr_addr_o, ctrl_wr_data_o});
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Fill a whole page through the load port, back to back
  task automatic load_page(input logic [1:0] pg);
    logic [15:0] d;
    for (int a = 0; a < 64; a++)
    begin
      d = rnd();
      @(posedge clk_i);
      load_wr_i <= 1'b1;
      load_page_i <= pg;
      load_addr_i <= a[5:0];
      load_data_i <= d;
      mem[{pg, a[5:0]}] = d;
    end
    @(posedge clk_i);
    load_wr_i <= 1'b0;
  endtask

  // One frame: command, then n data words (n_last bits of the final one)
  task automatic run(input logic [15:0] cmd, input int n, input int n_last);
    int pg, ad;
    logic [15:0] rx, d, exp;
    pg = cmd[14:11];
    ad = cmd[10:5];
    i_spi_host_model.open_frame();
    i_spi_host_model.shift(cmd, 16, rx);
    check(rx, 16'h0000);
    check(frame_busy_o, 1'b1);
    check(miso_oe_o, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      d = rnd();
      i_spi_host_model.shift(d, (k == n - 1) ? n_last : 16, rx);
      exp = (pg < 4 && ad < 64) ? mem[pg * 64 + ad] : FILL_WORD;
      if (cmd[15])
        check(rx, exp);
      else if (ad < 64 && (pg == 1 || pg == 2) && !(k == n - 1 && n_last < 16))
      begin
        mem[pg * 64 + ad] = d;
        exp_q.push_back({pg[1:0], ad[5:0], d});
      end
      ad++;
    end
    i_spi_host_model.close_frame();
    check(miso_oe_o, 1'b0);
    check(frame_busy_o, 1'b0);
    check(obs_q.size(), exp_q.size());
    while (obs_q.size() > 0 && exp_q.size() > 0)
      check(obs_q.pop_front(), exp_q.pop_front());
    obs_q.delete();
    exp_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    load_page(2'h0);
    load_page(2'h3);
    run(CMD_READ_P0, 66, 16);
    run(CMD_WRITE_P1, 9, 16);
    run(16'h08a0, 1, 8);
    run(16'h8800, 9, 16);
    run(16'h17c0, 3, 16);
    run(16'h97c0, 3, 16);
    run(16'h0060, 1, 16);
    run(16'h8060, 1, 16);
    run(16'h9fa0, 5, 16);
    for (int p = 4; p < 16; p++)
      run(16'h8000 | (p << 11), 1, 16);
    run(16'h2000, 1, 16);
    wrap_up();
  end

  // Hang guard: the sequence needs about 180 us, so 300 us is ample
  initial
  begin
    #300000;
    error_cnt++;
    wrap_up();
  end
endmodule
